// [hd2_consts.svh]
// Offsets, field positions, reset values and line constants of the second HDLC link controller.
`ifndef HD2_CONSTS_SVH
`define HD2_CONSTS_SVH
`define HD2_CTRL_IDX 12'h143
`define HD2_BOSCODE_IDX 12'h14C
`define HD2_STATUS_IDX 12'h14D
`define HD2_CTRL_RESET 7'h00
`define HD2_BIT_RESERVED 7
`define HD2_BIT_AUTO_ABORT_INHIBIT 6
`define HD2_BIT_RX_CHECK_OFF 5
`define HD2_BIT_DUP_DISCARD 4
`define HD2_BIT_FORCE_ABORT 3
`define HD2_BIT_FLAG_FILL 2
`define HD2_BIT_TX_CHECK_APPEND 1
`define HD2_BIT_SIGNALLING_SELECT 0
`define HD2_FLAG_OCTET 8'h7E
`define HD2_ABORT_OCTET 8'hFE
`define HD2_CRC_INIT 16'hFFFF
`define HD2_CRC_POLY 16'h8408
`define HD2_CRC_RESIDUE 16'hF0B8
`define HD2_STUFF_RUN 3'h5
`define HD2_MIN_FRAME_BITS 16'h0020
`endif

// [hd2_pkg.sv]
// Types shared by the second HDLC link controller.
`default_nettype none
package hd2_pkg;
  typedef enum logic [2:0] {
    TX_FLAG,
    TX_DATA,
    TX_FCS,
    TX_ABORT,
    TX_BOS,
    TX_ONES
  } hd2_tx_state_t;

  // Software-visible control fields, bit 7 omitted because it is reserved.
  typedef struct packed {
    logic autoAbortInhibit;
    logic rxCheckOff;
    logic duplicateDiscardEn;
    logic forceAbort;
    logic flagFill;
    logic txCheckAppend;
    logic signallingTypeSelect;
  } hd2_ctrl_t;

  // End-of-frame report towards the receive buffer.
  typedef struct packed {
    logic done;
    logic keep;
    logic fcsBad;
    logic duplicate;
  } hd2_rx_report_t;
endpackage : hd2_pkg
`default_nettype wire

// [hd2_link_ctrl.sv]
// Control, transmit framer and receive deframer of the second HDLC link controller.
//
// Behaviour
// R1 - Software writes zero to reserved bit 7.
// R2 - Auto abort on message-to-bit-oriented switch.
// R3 - Inhibit bit suppresses that automatic abort.
// R4 - Receive FCS checked unless check-off set.
// R5 - Duplicate discard drops frames matching held content.
// R6 - Force-abort bit sends continuous ones.
// R7 - Flag fill overrides pending message frames.
// R8 - Idle line carries repeated flag octets.
// R9 - Flag fill ignored in bit-oriented mode.
// R10 - Append bit adds FCS after frames.
// R11 - Append bit ignored in bit-oriented mode.
// R12 - Select bit picks bit or message oriented.
// R13 - Select written zero for each bit-oriented message.
// R14 - Zero-bit insertion on frame contents, removal on receive.
`include "hd2_consts.svh"
`default_nettype none
module hd2_link_ctrl
  import hd2_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic txMsgValid,
  input wire logic [7:0] txMsgData,
  input wire logic txMsgLast,
  output logic txMsgReady,
  input wire logic dlTxStrobe,
  output logic dlTxBit,
  input wire logic dlRxStrobe,
  input wire logic dlRxBit,
  output logic [7:0] rxOctet,
  output logic rxOctetValid,
  output hd2_rx_report_t rxReport,
  output logic rxBosValid,
  output logic [5:0] rxBosCode
);

  // Byte address of a register index; the printed offsets are not word aligned.
  function automatic logic [ADDR_W-1:0] regAddr(input logic [11:0] idx);
    regAddr = ADDR_W'({idx, 2'b00});
  endfunction : regAddr

  // One bit of the reflected CCITT CRC, shared by both directions.
  function automatic logic [15:0] crcBit(input logic [15:0] crc, input logic b);
    crcBit = (crc >> 1) ^ ((crc[0] ^ b) ? `HD2_CRC_POLY : 16'h0000);
  endfunction : crcBit

  hd2_ctrl_t ctrl;
  hd2_tx_state_t txState;
  logic [5:0] bosCodeReg;
  logic [15:0] txShift, txCrc, rxWin, rxBits, rxCrc, next_rxWin;
  logic [4:0] txLeft;
  logic [2:0] txOnes, rxOnes, rxFill;
  logic [7:0] holdByte, rxSr;
  logic [6:0] rxDly;
  logic [31:0] keptSig;
  logic bosPending, txStuffOn, txLastLoaded, holdLast, holdFull, next_holdFull;
  logic stuffNow, txLoad, consume, fillActive, appendActive, apbSetup, apbWrite;
  logic rxInFrame, keptValid;

  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pready && pwrite;
  // Flag fill and FCS append only mean anything in message-oriented mode.
  assign fillActive = ctrl.flagFill && ctrl.signallingTypeSelect; // see R9
  assign appendActive = ctrl.txCheckAppend && ctrl.signallingTypeSelect; // see R11
  assign stuffNow = (txOnes == `HD2_STUFF_RUN); // see R14
  assign txLoad = dlTxStrobe && !stuffNow && (txLeft == 5'd1);
  assign consume = txLoad && holdFull && !ctrl.forceAbort && !bosPending && !fillActive
    && ((txState == TX_DATA && !txLastLoaded)
    || (txState == TX_FLAG && ctrl.signallingTypeSelect));

  // APB answers one cycle after setup, so read data and error are registered in setup.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= apbSetup;
      if (apbSetup) begin
        pslverr <= 1'b0;
        if (paddr == regAddr(`HD2_CTRL_IDX)) begin
          prdata <= {25'h000_0000, ctrl}; // see R1
        end else if (paddr == regAddr(`HD2_BOSCODE_IDX)) begin
          prdata <= {26'h000_0000, bosCodeReg};
        end else if (paddr == regAddr(`HD2_STATUS_IDX)) begin
          prdata <= {25'h000_0000, rxInFrame, rxReport.fcsBad, rxReport.duplicate,
            keptValid, bosPending, txState != TX_FLAG, holdFull};
        end else begin
          prdata <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Control writes; the reserved top bit is dropped on the way in.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl <= `HD2_CTRL_RESET;
      bosCodeReg <= 6'h00;
    end else if (apbWrite) begin
      if (paddr == regAddr(`HD2_CTRL_IDX)) begin
        ctrl <= pwdata[6:0]; // see R1
      end else if (paddr == regAddr(`HD2_BOSCODE_IDX)) begin
        bosCodeReg <= pwdata[5:0];
      end
    end
  end

  // Each control write with the select bit low queues one bit-oriented message.
  // A new request in the cycle the old one is loaded wins over the clear.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bosPending <= 1'b0;
    end else if (apbWrite && paddr == regAddr(`HD2_CTRL_IDX)
        && !pwdata[`HD2_BIT_SIGNALLING_SELECT]) begin
      bosPending <= 1'b1; // see R12, R13
    end else if (txLoad && !ctrl.forceAbort
        && !((txState == TX_DATA || txState == TX_FCS) && !ctrl.autoAbortInhibit)) begin
      bosPending <= 1'b0; // see R2, R3
    end
  end

  // One-byte holding stage in front of the shifter hides the load latency.
  always_comb begin
    next_holdFull = holdFull;
    if (consume) begin
      next_holdFull = 1'b0;
    end else if (txMsgValid && txMsgReady) begin
      next_holdFull = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      holdFull <= 1'b0;
      holdByte <= 8'h00;
      holdLast <= 1'b0;
      txMsgReady <= 1'b0;
    end else begin
      holdFull <= next_holdFull;
      txMsgReady <= !next_holdFull;
      if (txMsgValid && txMsgReady) begin
        holdByte <= txMsgData;
        holdLast <= txMsgLast;
      end
    end
  end

  // Transmit shifter: LSB first, one bit per channel strobe, next unit loaded on the last bit.
  // Priority at a load: forced abort, queued bit-oriented message, frame tail, frame data, flags.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txState <= TX_FLAG;
      txShift <= {8'h00, `HD2_FLAG_OCTET};
      txLeft <= 5'd8;
      txStuffOn <= 1'b0;
      txOnes <= 3'h0;
      txCrc <= `HD2_CRC_INIT;
      txLastLoaded <= 1'b0;
      dlTxBit <= 1'b1;
    end else if (dlTxStrobe) begin
      if (stuffNow) begin
        dlTxBit <= 1'b0; // see R14
        txOnes <= 3'h0;
      end else begin
        dlTxBit <= txShift[0];
        txShift <= txShift >> 1;
        txLeft <= txLeft - 5'd1;
        // Only stuffed content counts; the run carries over into the closing flag.
        txOnes <= (txShift[0] && txStuffOn) ? txOnes + 3'h1 : 3'h0;
        if (txState == TX_DATA) begin
          txCrc <= crcBit(txCrc, txShift[0]);
        end
      end
      if (txLoad) begin
        if (ctrl.forceAbort) begin
          txState <= TX_ONES; // see R6
          txShift <= 16'hFFFF;
          txLeft <= 5'd16;
          txStuffOn <= 1'b0;
        end else if (bosPending && (txState == TX_DATA || txState == TX_FCS)
            && !ctrl.autoAbortInhibit) begin
          txState <= TX_ABORT; // see R2
          txShift <= {8'h00, `HD2_ABORT_OCTET};
          txLeft <= 5'd8;
          txStuffOn <= 1'b0;
        end else if (bosPending) begin
          txState <= TX_BOS; // see R3, R12
          txShift <= {1'b0, bosCodeReg, 1'b0, 8'hFF};
          txLeft <= 5'd16;
          txStuffOn <= 1'b0;
        end else if (txState == TX_DATA && (fillActive || (!txLastLoaded && !holdFull))) begin
          txState <= TX_ABORT; // see R7
          txShift <= {8'h00, `HD2_ABORT_OCTET};
          txLeft <= 5'd8;
          txStuffOn <= 1'b0;
        end else if (txState == TX_DATA && txLastLoaded && appendActive) begin
          txState <= TX_FCS; // see R10
          txShift <= ~crcBit(txCrc, txShift[0]);
          txLeft <= 5'd16;
          txStuffOn <= 1'b1;
        end else if (consume) begin
          if (txState == TX_FLAG) begin
            txCrc <= `HD2_CRC_INIT;
          end
          txState <= TX_DATA;
          txShift <= {8'h00, holdByte};
          txLeft <= 5'd8;
          txStuffOn <= 1'b1; // see R14
          txLastLoaded <= holdLast;
        end else begin
          txState <= TX_FLAG; // see R7, R8
          txShift <= {8'h00, `HD2_FLAG_OCTET};
          txLeft <= 5'd8;
          txStuffOn <= 1'b0;
        end
      end
    end
  end

  // Raw receive window, consecutive-ones counter and bit-oriented message detection.
  assign next_rxWin = {dlRxBit, rxWin[15:1]};
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rxWin <= 16'h0000;
      rxOnes <= 3'h0;
      rxBosValid <= 1'b0;
      rxBosCode <= 6'h00;
    end else begin
      rxBosValid <= 1'b0;
      if (dlRxStrobe) begin
        rxWin <= next_rxWin;
        rxOnes <= dlRxBit ? ((rxOnes == 3'h7) ? 3'h7 : rxOnes + 3'h1) : 3'h0;
        if (next_rxWin[7:0] == 8'hFF && !next_rxWin[8] && !next_rxWin[15]) begin
          rxBosCode <= next_rxWin[14:9];
          rxBosValid <= !(ctrl.duplicateDiscardEn && next_rxWin[14:9] == rxBosCode); // see R5
        end
      end
    end
  end

  // Deframer: flags delimit, seven ones abort, stuffed zeros vanish, and a
  // seven-bit delay keeps the tail of the closing flag out of the data.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rxDly <= 7'h00;
      rxFill <= 3'h0;
      rxSr <= 8'h00;
      rxBits <= 16'h0000;
      rxCrc <= `HD2_CRC_INIT;
      rxInFrame <= 1'b0;
      rxOctet <= 8'h00;
      rxOctetValid <= 1'b0;
      rxReport <= '0;
      keptSig <= 32'h0000_0000;
      keptValid <= 1'b0;
    end else begin
      rxOctetValid <= 1'b0;
      rxReport.done <= 1'b0;
      if (dlRxStrobe) begin
        if (dlRxBit && rxOnes == 3'h6) begin
          rxInFrame <= 1'b0;
          rxFill <= 3'h0;
        end else if (!dlRxBit && rxOnes == 3'h6) begin
          if (rxInFrame && rxBits != 16'h0000) begin
            rxReport.done <= 1'b1;
            rxReport.fcsBad <= !ctrl.rxCheckOff && rxCrc != `HD2_CRC_RESIDUE; // see R4
            rxReport.duplicate <= ctrl.duplicateDiscardEn && keptValid
              && keptSig == {rxCrc, rxBits}; // see R5
            rxReport.keep <= rxBits[2:0] == 3'h0 && rxBits >= `HD2_MIN_FRAME_BITS
              && (ctrl.rxCheckOff || rxCrc == `HD2_CRC_RESIDUE)
              && !(ctrl.duplicateDiscardEn && keptValid && keptSig == {rxCrc, rxBits});
            if (rxBits[2:0] == 3'h0 && rxBits >= `HD2_MIN_FRAME_BITS
                && (ctrl.rxCheckOff || rxCrc == `HD2_CRC_RESIDUE)) begin
              keptSig <= {rxCrc, rxBits};
              keptValid <= 1'b1;
            end
          end
          rxInFrame <= 1'b1;
          rxFill <= 3'h0;
          rxBits <= 16'h0000;
          rxCrc <= `HD2_CRC_INIT;
        end else if (!(!dlRxBit && rxOnes == `HD2_STUFF_RUN)) begin // see R14
          rxDly <= {dlRxBit, rxDly[6:1]};
          if (rxFill != 3'h7) begin
            rxFill <= rxFill + 3'h1;
          end else if (rxInFrame) begin
            rxCrc <= crcBit(rxCrc, rxDly[0]);
            rxSr <= {rxDly[0], rxSr[7:1]};
            rxBits <= rxBits + 16'h0001;
            if (rxBits[2:0] == 3'h7) begin
              rxOctet <= {rxDly[0], rxSr[7:1]};
              rxOctetValid <= 1'b1;
            end
          end
        end
      end
    end
  end

  // Checks on the transmit sequencing and the receive reports.
  sequence loadInFrame;
    txLoad && !ctrl.forceAbort && bosPending && (txState == TX_DATA || txState == TX_FCS);
  endsequence

  sequence loadAtIdle;
    txLoad && !ctrl.forceAbort && !bosPending && txState == TX_FLAG;
  endsequence

  chk_auto_abort_sent: assert property (@(posedge ref_clk) disable iff (rst) // see R2
    loadInFrame ##0 !ctrl.autoAbortInhibit |=> txState == TX_ABORT ##1 bosPending)
    else $error("Abort not sent before bit-oriented message.");

  chk_abort_inhibited: assert property (@(posedge ref_clk) disable iff (rst) // see R3
    loadInFrame ##0 ctrl.autoAbortInhibit |=> txState == TX_BOS && !bosPending)
    else $error("Abort sent while inhibited.");

  chk_force_ones: assert property (@(posedge ref_clk) disable iff (rst) // see R6
    dlTxStrobe && txState == TX_ONES && !stuffNow |=> dlTxBit)
    else $error("Forced abort emitted a zero.");

  chk_flag_fill_holds: assert property (@(posedge ref_clk) disable iff (rst) // see R7
    loadAtIdle ##0 fillActive |=> txState == TX_FLAG && txShift[7:0] == `HD2_FLAG_OCTET)
    else $error("Frame started during flag fill.");

  chk_idle_flags: assert property (@(posedge ref_clk) disable iff (rst) // see R8
    loadAtIdle ##0 !holdFull |=> txState == TX_FLAG)
    else $error("Idle line not filled with flags.");

  chk_fill_ignored_bos: assert property (@(posedge ref_clk) disable iff (rst) // see R9
    txLoad && !ctrl.forceAbort && bosPending && txState == TX_FLAG && ctrl.flagFill
    |=> txState == TX_BOS)
    else $error("Flag fill blocked a bit-oriented message.");

  chk_fcs_appended: assert property (@(posedge ref_clk) disable iff (rst) // see R10, R11
    txLoad && !ctrl.forceAbort && !bosPending && !fillActive && txState == TX_DATA
    && txLastLoaded |=> (txState == TX_FCS) == $past(appendActive))
    else $error("FCS append does not follow the control bits.");

  chk_zero_inserted: assert property (@(posedge ref_clk) disable iff (rst) // see R14
    dlTxStrobe && txOnes == 3'h5 |=> !dlTxBit && txOnes == 3'h0)
    else $error("No zero after five frame ones.");

  chk_rx_check: assert property (@(posedge ref_clk) disable iff (rst) // see R4
    rxReport.done && rxReport.fcsBad |-> !rxReport.keep && !ctrl.rxCheckOff)
    else $error("Bad FCS frame kept or reported while checking is off.");

  chk_dup_dropped: assert property (@(posedge ref_clk) disable iff (rst) // see R5
    rxReport.done && rxReport.duplicate |-> !rxReport.keep && ctrl.duplicateDiscardEn)
    else $error("Duplicate frame kept.");

endmodule : hd2_link_ctrl
`default_nettype wire

// [hd2_remote_peer.sv]
// Remote data-link terminal model: decodes the link output and sends frames on the link input.
`include "hd2_consts.svh"
`default_nettype none
module hd2_remote_peer (
  input wire logic ref_clk,
  input wire logic rst,
  output logic dlTxStrobe,
  input wire logic dlTxBit,
  output logic dlRxStrobe,
  output logic dlRxBit
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] gotQ[$];
  logic curQ[$];
  logic sendQ[$];
  logic [7:0] shReg, oct;
  logic takeNext;
  int run, flags, frames, longOnes, stuffRun;
  bit inFrame;

  // Decodes the line; irregular strobes make sure the transmitter never leans on a fixed bit rate.
  always @(posedge ref_clk) begin
    dlTxStrobe <= !rst && ($urandom_range(3) != 0);
    takeNext <= !rst && dlTxStrobe;
    if (takeNext) begin
      shReg = {dlTxBit, shReg[7:1]};
      if (shReg == `HD2_FLAG_OCTET) begin
        flags++;
        if (inFrame && curQ.size() >= 15 && (curQ.size() - 7) % 8 == 0) begin
          repeat (7) void'(curQ.pop_back());
          frames++;
          while (curQ.size() > 0) begin
            for (int i = 0; i < 8; i++) oct[i] = curQ.pop_front();
            gotQ.push_back(oct);
          end
        end
        curQ.delete();
        inFrame = 1'b1;
      end else if (dlTxBit || run != 5) begin
        curQ.push_back(dlTxBit);
      end
      if (!dlTxBit && run >= 7) longOnes += run;
      run = dlTxBit ? run + 1 : 0;
      if (run >= 7) inFrame = 1'b0;
    end
  end

  // Sends one bit every second cycle; an empty queue gets flags so the line never floats.
  always @(posedge ref_clk) begin
    if (rst) begin
      dlRxStrobe <= 1'b0;
      dlRxBit <= 1'b1;
    end else if (dlRxStrobe) begin
      dlRxStrobe <= 1'b0;
    end else begin
      if (sendQ.size() == 0) push_octet(`HD2_FLAG_OCTET, 1'b0);
      dlRxBit <= sendQ.pop_front();
      dlRxStrobe <= 1'b1;
    end
  end

  // Queues one octet, least significant bit first.
  task automatic push_octet(input logic [7:0] v, input bit stuff);
    for (int i = 0; i < 8; i++) begin
      sendQ.push_back(v[i]);
      stuffRun = v[i] ? stuffRun + 1 : 0;
      if (stuff && stuffRun == 5) begin
        sendQ.push_back(1'b0);
        stuffRun = 0;
      end
    end
  endtask : push_octet

  // Queues a whole frame between two flags.
  task automatic send_frame(input logic [7:0] q[$]);
    push_octet(`HD2_FLAG_OCTET, 1'b0);
    foreach (q[i]) push_octet(q[i], 1'b1);
    push_octet(`HD2_FLAG_OCTET, 1'b0);
  endtask : send_frame

  // Clears the counters between tests.
  task automatic clear_stats();
    flags = 0;
    frames = 0;
    longOnes = 0;
    gotQ.delete();
  endtask : clear_stats
endmodule : hd2_remote_peer
`default_nettype wire

// [tb_top.sv]
// Self-checking bench of the second HDLC link controller against a remote terminal model.
`include "hd2_consts.svh"
`default_nettype none
module tb_top
  import hd2_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] CTRL_ADDR = 12'(`HD2_CTRL_IDX * 4);
  localparam logic [11:0] BOS_ADDR = 12'(`HD2_BOSCODE_IDX * 4);
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdv, rnd;
  logic pready, pslverr, errv, txMsgReady, dlTxStrobe, dlTxBit, dlRxStrobe, dlRxBit;
  logic txMsgValid = 1'b0;
  logic txMsgLast = 1'b0;
  logic [7:0] txMsgData = 8'h00;
  logic [7:0] rxOctet, gotRx[$], expQ[$], dataQ[$];
  logic rxOctetValid, rxBosValid;
  logic [5:0] rxBosCode;
  hd2_rx_report_t rxReport, lastRep;
  int fails = 0;
  int cmpCount = 0;
  int cycles = 0;
  int reps = 0;
  int bosSeen = 0;
  logic [5:0] bosGot = 6'h00;
  bit stopTx = 1'b0;

  hd2_link_ctrl hd2_link_ctrl_inst (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .txMsgValid(txMsgValid), .txMsgData(txMsgData), .txMsgLast(txMsgLast),
    .txMsgReady(txMsgReady), .dlTxStrobe(dlTxStrobe), .dlTxBit(dlTxBit),
    .dlRxStrobe(dlRxStrobe), .dlRxBit(dlRxBit), .rxOctet(rxOctet),
    .rxOctetValid(rxOctetValid), .rxReport(rxReport), .rxBosValid(rxBosValid),
    .rxBosCode(rxBosCode)
  );
  hd2_remote_peer peer (
    .ref_clk(ref_clk), .rst(rst), .dlTxStrobe(dlTxStrobe), .dlTxBit(dlTxBit),
    .dlRxStrobe(dlRxStrobe), .dlRxBit(dlRxBit)
  );

  // Free-running clock.
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  // Collects received octets and reports; the cycle ceiling stops a hung run.
  always @(posedge ref_clk) begin
    cycles++;
    if (rxOctetValid === 1'b1) gotRx.push_back(rxOctet);
    if (rxBosValid === 1'b1) begin
      bosGot = rxBosCode;
      bosSeen++;
    end
    if (rxReport.done === 1'b1) begin
      lastRep = rxReport;
      reps++;
    end
    if (cycles == 20000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_q(input logic [7:0] got[$], input logic [7:0] exp[$]);
    check_word(got.size(), exp.size());
    foreach (exp[i]) if (i < got.size()) check_word(got[i], exp[i]);
  endtask : check_q

  // One APB transfer; the request holds until pready is seen high at an edge.
  task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic ctrl(input logic [31:0] v);
    apb(1'b1, CTRL_ADDR, v);
  endtask : ctrl

  task automatic wait_until(ref int v, input int n);
    int k = 0;
    while (v < n && k < 3000) begin
      @(posedge ref_clk);
      k++;
    end
    check_word(v, n);
  endtask : wait_until

  // Streams message bytes; stopTx lets a test walk away from a stalled stream.
  task automatic send_msg(input logic [7:0] q[$]);
    int n;
    foreach (q[i]) begin
      txMsgValid <= 1'b1;
      txMsgData <= q[i];
      txMsgLast <= (i == q.size() - 1);
      n = 0;
      do begin
        @(posedge ref_clk);
        n++;
      end while (txMsgReady !== 1'b1 && !stopTx && n < 3000);
      if (stopTx) break;
    end
    txMsgValid <= 1'b0;
    txMsgLast <= 1'b0;
  endtask : send_msg

  // Flag and all-ones octets up front force zero insertion in every frame.
  task automatic new_data();
    dataQ = {8'h7E, 8'hFF};
    repeat (4) dataQ.push_back(8'($urandom));
  endtask : new_data

  task automatic add_fcs(ref logic [7:0] q[$]);
    logic [15:0] c = `HD2_CRC_INIT;
    foreach (q[i]) begin
      for (int b = 0; b < 8; b++) c = (c[0] ^ q[i][b]) ? ((c >> 1) ^ `HD2_CRC_POLY) : (c >> 1);
    end
    q.push_back(~c[7:0]);
    q.push_back(~c[15:8]);
  endtask : add_fcs

  task automatic end_test(input string s);
    $display("test %s done at %0t", s, $time);
  endtask : end_test

  task automatic tx_case(input logic [31:0] c, input bit fill);
    new_data();
    expQ = dataQ;
    if (c[1]) add_fcs(expQ);
    ctrl(c);
    peer.clear_stats();
    fork
      send_msg(dataQ);
      if (fill) begin
        repeat (400) @(posedge ref_clk);
        check_word(peer.frames, 0);
        ctrl(c & 32'h7B);
      end
    join
    wait_until(peer.frames, 1);
    check_q(peer.gotQ, expQ);
    end_test("transmit");
  endtask : tx_case

  // Zero bytes keep ones out of the frame, so only abort and code runs are long.
  task automatic abort_case(input bit inh);
    dataQ = {};
    repeat (40) dataQ.push_back(8'h00);
    ctrl(32'h01);
    // Forced ones or a stale held byte must drain before long runs are counted.
    repeat (100) @(posedge ref_clk);
    peer.clear_stats();
    stopTx = 1'b0;
    fork
      send_msg(dataQ);
      begin
        repeat (120) @(posedge ref_clk);
        ctrl({25'h0, inh, 6'h00});
        repeat (150) @(posedge ref_clk);
        check_word(peer.longOnes, inh ? 8 : 15);
        stopTx = 1'b1;
      end
    join
    end_test("switch");
  endtask : abort_case

  task automatic rx_case(input logic [31:0] c, input bit bad, input bit keep, input bit dup);
    int r0 = reps;
    ctrl(c);
    expQ = dataQ;
    add_fcs(expQ);
    if (bad) expQ[expQ.size() - 1] ^= 8'h01;
    gotRx.delete();
    peer.send_frame(expQ);
    wait_until(reps, r0 + 1);
    check_q(gotRx, expQ);
    check_word({lastRep.keep, lastRep.duplicate}, {keep, dup});
    if (!c[5]) check_word(lastRep.fcsBad, bad);
    end_test("receive");
  endtask : rx_case

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmpCount, fails);
    if (fails == 0 && cmpCount > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  // Main sequence.
  initial begin
    void'($urandom(32'h55CF));
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    apb(1'b0, CTRL_ADDR, 32'h0);
    check_word(rdv, 32'(`HD2_CTRL_RESET));
    repeat (4) begin
      rnd = ($urandom & 32'h76) | 32'h01;
      ctrl(rnd);
      apb(1'b0, CTRL_ADDR, 32'h0);
      check_word(rdv, rnd);
    end
    apb(1'b1, 12'h004, 32'hFFFF_FFFF);
    apb(1'b0, 12'h004, 32'h0);
    check_word({errv, rdv[30:0]}, 32'h8000_0000);
    ctrl(32'h01);
    peer.clear_stats();
    repeat (300) @(posedge ref_clk);
    check_word(peer.flags >= 20, 1);
    check_word(peer.frames, 0);
    end_test("registers and idle");
    tx_case(32'h03, 1'b0);
    tx_case(32'h01, 1'b0);
    tx_case(32'h05, 1'b1);
    apb(1'b1, BOS_ADDR, 32'($urandom_range(63)));
    peer.clear_stats();
    ctrl(32'h06);
    repeat (200) @(posedge ref_clk);
    check_word(peer.longOnes, 8);
    check_word(peer.frames, 0);
    ctrl(32'h09);
    repeat (60) @(posedge ref_clk);
    check_word(peer.run >= 7, 1);
    end_test("code and forced abort");
    abort_case(1'b1);
    abort_case(1'b0);
    new_data();
    rx_case(32'h01, 1'b0, 1'b1, 1'b0);
    rx_case(32'h01, 1'b1, 1'b0, 1'b0);
    rx_case(32'h21, 1'b1, 1'b1, 1'b0);
    new_data();
    rx_case(32'h11, 1'b0, 1'b1, 1'b0);
    rx_case(32'h11, 1'b0, 1'b0, 1'b1);
    rx_case(32'h01, 1'b0, 1'b1, 1'b0);
    // The same bit-oriented code twice: only the first one is reported.
    ctrl(32'h11);
    rnd = 32'($urandom_range(63, 1));
    repeat (2) begin
      peer.push_octet(8'hFF, 1'b0);
      peer.push_octet({1'b0, rnd[5:0], 1'b0}, 1'b0);
    end
    repeat (200) @(posedge ref_clk);
    check_word(bosSeen, 1);
    check_word(bosGot, rnd);
    end_test("bit-oriented receive");
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
